// *** design/frxw_defs.svh ***
// frxw_defs.svh: constants of the fronthaul receive window monitor.
// assumes: included by the package and by each design file; definitions only.
`ifndef FRXW_DEFS_SVH
`define FRXW_DEFS_SVH

// ---------------------------------------------------------------
// widths
// ---------------------------------------------------------------
`define FRXW_TW 32
`define FRXW_SIDW 16
`define FRXW_CW 32
`define FRXW_NCLS 16

// ---------------------------------------------------------------
// stream identifier layout: radio port field in the low bits
// ---------------------------------------------------------------
`define FRXW_PORT_LSB 0
`define FRXW_PORT_W 4

// ---------------------------------------------------------------
// timing, in ticks of the symbol-time reference
// ---------------------------------------------------------------
`define FRXW_TICK_NS 100
`define FRXW_NS_PER_US 1000
`define FRXW_TICKS_PER_US (`FRXW_NS_PER_US / `FRXW_TICK_NS)

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define FRXW_CNT_RST 32'h0000_0000
`define FRXW_TIME_RST 32'h0000_0000

`endif

// *** design/frxw_pkg.sv ***
// frxw_pkg.sv: types of the fronthaul receive window monitor.
// assumes: frxw_defs.svh on the include path.
`include "frxw_defs.svh"
package frxw_pkg;
    typedef logic [`FRXW_TW-1:0] frxw_time_t;
    typedef logic [`FRXW_CW-1:0] frxw_cnt_t;
    typedef logic [`FRXW_SIDW-1:0] frxw_sid_t;
    // timing verdict of one packet
    typedef enum logic [1:0] {
        FRXW_ON_TIME,
        FRXW_EARLY,
        FRXW_LATE,
        FRXW_EXEMPT
    } frxw_verdict_t;
endpackage : frxw_pkg

// *** design/frxw_counter.sv ***
// frxw_counter.sv: one saturating event counter with synchronous clear.
// assumes: one clock, asynchronous active-low reset.
`timescale 1ns/10ps
`include "frxw_defs.svh"
module frxw_counter
    import frxw_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // control
    input wire logic inc_i,
    input wire logic clr_i,
    // count
    output frxw_cnt_t count_o
);
    typedef struct packed {
        frxw_cnt_t cnt;
    } frxw_cst_t;

    frxw_cst_t st_r; // registered state
    frxw_cst_t st_nxt; // next state

    // ---------------------------------------------------------------
    // next state: an increment in the clear cycle still counts
    // ---------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        if (clr_i) begin
            st_nxt.cnt = inc_i ? frxw_cnt_t'(1) : `FRXW_CNT_RST;
        end else if (inc_i && (st_r.cnt != {`FRXW_CW{1'b1}})) begin
            // saturate rather than wrap so a long run never reads small
            st_nxt.cnt = st_r.cnt + frxw_cnt_t'(1);
        end
    end

    // register
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r <= '{cnt: `FRXW_CNT_RST};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign count_o = st_r.cnt;
endmodule : frxw_counter

// *** design/frxw_monitor.sv ***
// frxw_monitor.sv: receive window monitor of a fronthaul endpoint.
// assumes: packet descriptors arrive on clk_i from the same-clock parser, one
// cycle pulse each; window bounds and exemption map are steady configuration.
`timescale 1ns/10ps
`include "frxw_defs.svh"

module frxw_monitor
    import frxw_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // packet descriptor from parser
    input wire logic pkt_valid_i,
    input wire frxw_sid_t stream_identifier_i,
    input wire frxw_time_t pkt_arrival_i,
    input wire frxw_time_t pkt_symbol_time_i,
    input wire logic [2:0] pkt_priority_i,
    input wire logic [`FRXW_PORT_W-1:0] pkt_payload_tag_i,
    // reception window relative to symbol time
    input wire frxw_time_t win_open_i,
    input wire frxw_time_t win_close_i,
    // exempt (non-delay-managed) radio port fields, one bit per value
    input wire logic [`FRXW_NCLS-1:0] exempt_port_map_i,
    // fixed timing advance configuration
    input wire frxw_time_t fixed_downlink_send_start_i,
    input wire frxw_time_t ru_latest_receive_limit_i,
    input wire frxw_time_t sender_max_spread_i,
    input wire frxw_time_t earliest_tx_latest_limit_i,
    input wire frxw_time_t latest_rx_latest_limit_i,
    input wire frxw_time_t measured_max_delay_i,
    input wire frxw_time_t ru_earliest_receive_limit_i,
    // counter clear
    input wire logic cnt_clear_i,
    // accepted packet out
    output logic acc_valid_o,
    output frxw_sid_t acc_stream_o,
    output frxw_time_t acc_symbol_time_o,
    output logic acc_exempt_o,
    output logic [1:0] acc_verdict_o,
    // counters
    output frxw_cnt_t cnt_on_time_o,
    output frxw_cnt_t cnt_early_o,
    output frxw_cnt_t cnt_late_o,
    output frxw_cnt_t cnt_exempt_o,
    output logic relatency_hint_o,
    // fixed advance figures
    output frxw_time_t min_downlink_transport_delay_o,
    output frxw_time_t fixed_advance_offset_o,
    output frxw_time_t supported_range_o
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic acc_valid;
        frxw_sid_t acc_stream;
        frxw_time_t acc_sym;
        logic acc_exempt;
        frxw_verdict_t verdict;
        logic hint;
        frxw_time_t min_delay;
        frxw_time_t offset;
        frxw_time_t range;
    } frxw_st_t;

    frxw_st_t st_r; // registered state
    frxw_st_t st_nxt; // next state

    // ---------------------------------------------------------------
    // classification and window test
    // ---------------------------------------------------------------
    logic [`FRXW_PORT_W-1:0] port_field; // radio port field of the stream
    logic is_exempt; // non-delay-managed flow
    frxw_time_t win_start; // absolute window opening
    frxw_time_t win_end; // absolute window closing
    logic before_win; // arrived before opening
    logic after_win; // arrived after closing
    frxw_verdict_t verdict; // verdict of the current packet
    logic inc_on; // counter strobes
    logic inc_early;
    logic inc_late;
    logic inc_exempt;

    // kind comes from the port field only; priority is never looked at
    assign port_field = stream_identifier_i[`FRXW_PORT_LSB +: `FRXW_PORT_W];
    assign is_exempt = exempt_port_map_i[port_field];

    // window is anchored on the symbol time the packet carries
    assign win_start = pkt_symbol_time_i + win_open_i;
    assign win_end = pkt_symbol_time_i + win_close_i;
    // signed differences tolerate wrap of the free-running time base
    assign before_win = $signed(pkt_arrival_i - win_start) < 0;
    assign after_win = $signed(pkt_arrival_i - win_end) > 0;

    // verdict: exactly one outcome per packet
    always_comb begin
        if (is_exempt) begin
            verdict = FRXW_EXEMPT;
        end else if (before_win) begin
            verdict = FRXW_EARLY;
        end else if (after_win) begin
            verdict = FRXW_LATE;
        end else begin
            verdict = FRXW_ON_TIME;
        end
    end

    assign inc_on = pkt_valid_i && (verdict == FRXW_ON_TIME);
    assign inc_early = pkt_valid_i && (verdict == FRXW_EARLY);
    assign inc_late = pkt_valid_i && (verdict == FRXW_LATE);
    assign inc_exempt = pkt_valid_i && (verdict == FRXW_EXEMPT);

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        // every packet is forwarded, late or early; the monitor only counts
        st_nxt.acc_valid = pkt_valid_i;
        if (pkt_valid_i) begin
            st_nxt.acc_stream = stream_identifier_i;
            st_nxt.acc_sym = pkt_symbol_time_i;
            st_nxt.acc_exempt = is_exempt;
            st_nxt.verdict = verdict;
        end
        // early arrival suggests link latency should be measured again
        if (cnt_clear_i) begin
            st_nxt.hint = inc_early; // set wins over clear
        end else if (inc_early) begin
            st_nxt.hint = 1'b1;
        end
        // fixed send start pins the shortest transport delay
        st_nxt.min_delay = fixed_downlink_send_start_i
                         - (ru_latest_receive_limit_i - sender_max_spread_i);
        // offset: spare advance beyond measured max, zero at full range
        if (earliest_tx_latest_limit_i > measured_max_delay_i + ru_earliest_receive_limit_i) begin
            st_nxt.offset = earliest_tx_latest_limit_i
                          - measured_max_delay_i - ru_earliest_receive_limit_i;
        end else begin
            st_nxt.offset = `FRXW_TIME_RST;
        end
        // range bounded by earliest transmit and latest receive limits
        st_nxt.range = (earliest_tx_latest_limit_i < latest_rx_latest_limit_i)
                     ? earliest_tx_latest_limit_i : latest_rx_latest_limit_i;
    end

    // register
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r <= '{acc_valid: 1'b0, acc_stream: '0, acc_sym: `FRXW_TIME_RST,
                      acc_exempt: 1'b0, verdict: FRXW_ON_TIME, hint: 1'b0,
                      min_delay: `FRXW_TIME_RST, offset: `FRXW_TIME_RST,
                      range: `FRXW_TIME_RST};
        end else begin
            st_r <= st_nxt;
        end
    end

    // ---------------------------------------------------------------
    // counters
    // ---------------------------------------------------------------
    frxw_counter u_cnt_on (
        .clk_i(clk_i), .nrst_i(nrst_i), .inc_i(inc_on), .clr_i(cnt_clear_i),
        .count_o(cnt_on_time_o)
    );
    frxw_counter u_cnt_early (
        .clk_i(clk_i), .nrst_i(nrst_i), .inc_i(inc_early), .clr_i(cnt_clear_i),
        .count_o(cnt_early_o)
    );
    frxw_counter u_cnt_late (
        .clk_i(clk_i), .nrst_i(nrst_i), .inc_i(inc_late), .clr_i(cnt_clear_i),
        .count_o(cnt_late_o)
    );
    frxw_counter u_cnt_exempt (
        .clk_i(clk_i), .nrst_i(nrst_i), .inc_i(inc_exempt), .clr_i(cnt_clear_i),
        .count_o(cnt_exempt_o)
    );

    // outputs straight from flip-flops
    assign acc_valid_o = st_r.acc_valid;
    assign acc_stream_o = st_r.acc_stream;
    assign acc_symbol_time_o = st_r.acc_sym;
    assign acc_exempt_o = st_r.acc_exempt;
    assign acc_verdict_o = st_r.verdict;
    assign relatency_hint_o = st_r.hint;
    assign min_downlink_transport_delay_o = st_r.min_delay;
    assign fixed_advance_offset_o = st_r.offset;
    assign supported_range_o = st_r.range;

    // pkt_priority_i and pkt_payload_tag_i are deliberately unused
endmodule : frxw_monitor

// *** tb/frxw_monitor_sva.sv ***
// frxw_monitor_sva.sv: port checks of the receive window monitor.
// assumes: bound to frxw_monitor; one clock, async active-low reset.
`timescale 1ns/10ps
`include "frxw_defs.svh"
module frxw_monitor_sva
    import frxw_pkg::*;
(
    // clock, reset and packet in
    input wire logic clk_i, nrst_i, pkt_valid_i, cnt_clear_i,
    input wire frxw_sid_t stream_identifier_i,
    input wire frxw_time_t pkt_arrival_i, pkt_symbol_time_i,
    input wire frxw_time_t win_open_i, win_close_i,
    input wire logic [`FRXW_NCLS-1:0] exempt_port_map_i,
    // outputs watched
    input wire logic acc_valid_o, acc_exempt_o, relatency_hint_o,
    input wire logic [1:0] acc_verdict_o,
    input wire frxw_time_t acc_symbol_time_o,
    input wire frxw_cnt_t cnt_on_time_o, cnt_early_o, cnt_late_o, cnt_exempt_o
);
    // ------------------------------------------------------------
    // expected verdict, signed so wrapped time still compares
    // ------------------------------------------------------------
    frxw_time_t d_open, d_close; // arrival relative to each bound
    logic [1:0] v; // verdict this packet deserves
    assign d_open = pkt_arrival_i - pkt_symbol_time_i - win_open_i;
    assign d_close = pkt_arrival_i - pkt_symbol_time_i - win_close_i;
    assign v = exempt_port_map_i[stream_identifier_i[3:0]] ? 2'h3 :
        ($signed(d_open) < 0) ? 2'h1 : ($signed(d_close) > 0) ? 2'h2 : 2'h0;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    a_answer_next: assert property (pkt_valid_i |=> acc_valid_o)
        else $error("packet not answered");
    a_no_phantom: assert property (!pkt_valid_i |=> !acc_valid_o)
        else $error("answer without packet");
    a_verdict_cause: assert property (pkt_valid_i |=> acc_verdict_o == $past(v))
        else $error("wrong verdict");
    a_exempt_flag: assert property (pkt_valid_i |=> acc_exempt_o == ($past(v) == 2'h3))
        else $error("wrong exempt flag");
    a_one_count: assert property (pkt_valid_i && !cnt_clear_i |=>
        $countones({$changed(cnt_on_time_o), $changed(cnt_early_o),
        $changed(cnt_late_o), $changed(cnt_exempt_o)}) == 1)
        else $error("not exactly one counter moved");
    a_sym_kept: assert property (pkt_valid_i |=>
        acc_symbol_time_o == $past(pkt_symbol_time_i)) else $error("symbol time lost");
    a_early_hint: assert property (pkt_valid_i && v == 2'h1 |=> relatency_hint_o)
        else $error("hint not raised");
    a_clear_set_wins: assert property (cnt_clear_i && pkt_valid_i && v == 2'h1 |=>
        cnt_early_o == 32'h1 && cnt_on_time_o == 32'h0 && relatency_hint_o)
        else $error("clear beat a new event");
    a_clear_zero: assert property (cnt_clear_i && !pkt_valid_i |=>
        cnt_early_o == 32'h0 && cnt_on_time_o == 32'h0 && !relatency_hint_o)
        else $error("clear failed");
endmodule : frxw_monitor_sva

// *** tb/frxw_peer.sv ***
// frxw_peer.sv: behavioural peer endpoint that sends packet descriptors.
// assumes: bench raises send_i after an edge; descriptor leaves one edge later.
`timescale 1ns/10ps
module frxw_peer
    import frxw_pkg::*;
(
    // request from the bench
    input wire logic clk_i, send_i,
    input wire frxw_sid_t sid_i,
    input wire frxw_time_t arr_i,
    input wire logic [2:0] prio_i,
    // descriptor toward the monitor
    output logic pv_o,
    output frxw_sid_t sid_o,
    output frxw_time_t arr_o,
    output logic [2:0] prio_o
);
    // ------------------------------------------------------------
    // sender
    // ------------------------------------------------------------
    // idle fields flip every cycle so a stale descriptor never passes
    initial {pv_o, sid_o, arr_o, prio_o} = '0;
    always @(posedge clk_i) begin
        pv_o <= send_i;
        sid_o <= send_i ? sid_i : ~sid_o;
        arr_o <= send_i ? arr_i : ~arr_o;
        prio_o <= send_i ? prio_i : ~prio_o;
    end
endmodule : frxw_peer

// *** tb/testbench.sv ***
// testbench.sv: directed scenarios for the receive window monitor.
// assumes: frxw_peer feeds descriptors; checker bound at the foot.
`timescale 1ns/10ps
module testbench;
    import frxw_pkg::*;
    // ------------------------------------------------------------
    // signals, named as the monitor ports
    // ------------------------------------------------------------
    logic clk_i, pkt_valid_i, acc_valid_o, acc_exempt_o, relatency_hint_o;
    logic nrst_i = 1'b0, cnt_clear_i = 1'b0, send_r = 1'b0;
    logic [2:0] pkt_priority_i, prio_r = 3'h0;
    logic [1:0] acc_verdict_o;
    logic [3:0] pkt_payload_tag_i = 4'h5;
    logic [15:0] exempt_port_map_i = 16'h0080;
    frxw_sid_t stream_identifier_i, acc_stream_o, sid_r = 16'h0000;
    frxw_time_t pkt_arrival_i, acc_symbol_time_o, arr_r = 32'h0;
    frxw_time_t pkt_symbol_time_i = 32'h3E8, win_open_i = 32'h0A, win_close_i = 32'h14;
    frxw_time_t fixed_downlink_send_start_i = 32'h1F4, ru_latest_receive_limit_i = 32'h12C;
    frxw_time_t sender_max_spread_i = 32'h32, earliest_tx_latest_limit_i = 32'h190;
    frxw_time_t latest_rx_latest_limit_i = 32'h15E, measured_max_delay_i = 32'hC8;
    frxw_time_t ru_earliest_receive_limit_i = 32'h64;
    frxw_time_t min_downlink_transport_delay_o, fixed_advance_offset_o, supported_range_o;
    frxw_cnt_t cnt_on_time_o, cnt_early_o, cnt_late_o, cnt_exempt_o;
    int n_fail = 0;
    int samples_checked = 0;
    frxw_monitor dut (.*);
    frxw_peer peer (.clk_i(clk_i), .send_i(send_r), .sid_i(sid_r), .arr_i(arr_r),
        .prio_i(prio_r), .pv_o(pkt_valid_i), .sid_o(stream_identifier_i),
        .arr_o(pkt_arrival_i), .prio_o(pkt_priority_i));
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic summarize;
        $display("checked %0d failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : summarize
    // one packet; answer is due at the edge where the monitor takes it, one edge after the peer sends
    task automatic xfer(input frxw_sid_t s, input frxw_time_t a, input logic [2:0] p,
        input logic [1:0] ev);
        @(posedge clk_i);
        send_r <= 1'b1;
        sid_r <= s;
        arr_r <= a;
        prio_r <= p;
        @(posedge clk_i);
        send_r <= 1'b0;
        @(posedge clk_i);
        #1;
        chk(acc_valid_o, 1'b1);
        chk(acc_verdict_o, ev);
        chk(acc_exempt_o, ev == 2'h3);
        chk(acc_stream_o, s);
        chk(acc_symbol_time_o, pkt_symbol_time_i);
    endtask : xfer
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_window;
        xfer(16'h0001, 32'h3F7, 3'h0, 2'h0);
        xfer(16'h0001, 32'h3ED, 3'h0, 2'h1);
        xfer(16'h0001, 32'h401, 3'h0, 2'h2);
        chk(cnt_on_time_o, 32'h1);
        chk(cnt_early_o, 32'h1);
        chk(cnt_late_o, 32'h1);
        chk(relatency_hint_o, 1'b1);
    endtask : t_window
    task automatic t_exempt;
        xfer(16'h0127, 32'h5, 3'h0, 2'h3);
        xfer(16'h0F17, 32'h3F7, 3'h7, 2'h3);
        xfer(16'h0126, 32'h5, 3'h7, 2'h1);
        xfer(16'h0002, 32'h3F7, 3'h7, 2'h0);
        chk(cnt_exempt_o, 32'h2);
        chk(cnt_on_time_o, 32'h2);
    endtask : t_exempt
    task automatic t_b2b;
        @(posedge clk_i);
        send_r <= 1'b1;
        sid_r <= 16'h0001;
        arr_r <= 32'h3E9;
        @(posedge clk_i);
        arr_r <= 32'h3EA;
        @(posedge clk_i);
        send_r <= 1'b0;
        @(posedge clk_i);
        #1;
        chk(cnt_early_o, 32'h4);
        chk(cnt_late_o, 32'h1);
    endtask : t_b2b
    task automatic t_fixed;
        chk(min_downlink_transport_delay_o, 32'hFA);
        chk(supported_range_o, 32'h15E);
        chk(fixed_advance_offset_o, 32'h64);
        @(posedge clk_i);
        measured_max_delay_i <= 32'h12C;
        repeat (2) @(posedge clk_i);
        #1;
        chk(fixed_advance_offset_o, 32'h0);
    endtask : t_fixed
    task automatic t_clear;
        // early packet taken in the very cycle of the clear: the event wins
        @(posedge clk_i);
        send_r <= 1'b1;
        sid_r <= 16'h0001;
        arr_r <= 32'h3ED;
        @(posedge clk_i);
        send_r <= 1'b0;
        cnt_clear_i <= 1'b1;
        @(posedge clk_i);
        cnt_clear_i <= 1'b0;
        #1;
        chk(cnt_early_o, 32'h1);
        chk(relatency_hint_o, 1'b1);
        chk(cnt_on_time_o, 32'h0);
        // plain clear with no packet empties every counter and the hint
        @(posedge clk_i);
        cnt_clear_i <= 1'b1;
        @(posedge clk_i);
        cnt_clear_i <= 1'b0;
        #1;
        chk(cnt_early_o, 32'h0);
        chk(cnt_late_o, 32'h0);
        chk(cnt_exempt_o, 32'h0);
        chk(relatency_hint_o, 1'b0);
    endtask : t_clear
    initial begin
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        t_window();
        t_exempt();
        t_b2b();
        t_fixed();
        t_clear();
        summarize();
    end
endmodule : testbench
bind frxw_monitor frxw_monitor_sva chk_sva (.*);
